// >>> logic/cmpev_top.sv
// Comparator event logic: control, result capture, alarm pin, interrupt.
// Assumes an analog comparator outside giving an asynchronous level.
//
// Chosen here: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/1ns
module cmpev_top
(
   // Clock and reset
   input  wire logic                 clk_sys,
   input  wire logic                 rst_b,
   // AXI4-Lite write address
   input  wire logic                 s_axi_awvalid,
   output logic                      s_axi_awready,
   input  wire logic [7:0]           s_axi_awaddr,
   // AXI4-Lite write data
   input  wire logic                 s_axi_wvalid,
   output logic                      s_axi_wready,
   input  wire logic [31:0]          s_axi_wdata,
   input  wire logic [3:0]           s_axi_wstrb,
   // AXI4-Lite write response
   output logic                      s_axi_bvalid,
   input  wire logic                 s_axi_bready,
   output logic [1:0]                s_axi_bresp,
   // AXI4-Lite read address
   input  wire logic                 s_axi_arvalid,
   output logic                      s_axi_arready,
   input  wire logic [7:0]           s_axi_araddr,
   // AXI4-Lite read data
   output logic                      s_axi_rvalid,
   input  wire logic                 s_axi_rready,
   output logic [31:0]               s_axi_rdata,
   output logic [1:0]                s_axi_rresp,
   // Analog comparator
   input  wire logic                 cmpRaw,
   output cmpev_pkg::cmpev_ana_t     anaCtrl,
   // Pins
   output cmpev_pkg::cmpev_pin_t     alarmPin,
   output logic                      pinsToGpio,
   // Interrupt
   output logic                      irq
);

   // ---------------------------------------------------------------
   // Reset release
   // ---------------------------------------------------------------
   logic [1:0] rstPipe;
   logic       rstSync_b;

   always_ff @(posedge clk_sys or negedge rst_b)
   begin
      if (!rst_b)
         rstPipe <= 2'h0;
      else
         rstPipe <= {rstPipe[0], 1'b1};
   end
   assign rstSync_b = rstPipe[1];

   // ---------------------------------------------------------------
   // Comparator sampling
   // ---------------------------------------------------------------
   logic cmpSync;
   logic cmpPrev;
   logic trip;

   cmpev_sync u_sync
   (
      .clk_sys   (clk_sys),
      .rstSync_b (rstSync_b),
      .din       (cmpRaw),
      .dout      (cmpSync)
   );

   // ---------------------------------------------------------------
   // Register state
   // ---------------------------------------------------------------
   logic [cmpev_pkg::CTRL_W-1:0] ctrl,    next_ctrl;
   logic [cmpev_pkg::IRQ_W-1:0]  irqSt,   next_irqSt;
   logic [cmpev_pkg::IRQ_W-1:0]  irqMsk,  next_irqMsk;
   logic                         result,  next_result;
   logic                         next_cmpPrev;
   logic                         enable;

   // Bus state
   logic        awHeld, next_awHeld;
   logic        wHeld,  next_wHeld;
   logic [7:0]  awAddr, next_awAddr;
   logic [31:0] wData,  next_wData;
   logic        wByte0, next_wByte0;
   logic        bValid, next_bValid;
   logic [1:0]  bResp,  next_bResp;
   logic        rValid, next_rValid;
   logic [31:0] rData,  next_rData;
   logic [1:0]  rResp,  next_rResp;
   logic        doWrite;
   logic        clrHit;

   function automatic logic mapped(input logic [7:0] a);
      mapped = (a == cmpev_pkg::OFF_CTRL)  || (a == cmpev_pkg::OFF_STATUS) ||
               (a == cmpev_pkg::OFF_IRQST) || (a == cmpev_pkg::OFF_IRQMSK);
   endfunction

   assign enable = ctrl[cmpev_pkg::CTRL_EN];
   // Only rising-edge trips count; a level held high does not refire
   assign trip   = enable && cmpSync && !cmpPrev;
   assign doWrite = awHeld && wHeld && !bValid;
   assign clrHit = doWrite && wByte0 && (awAddr == cmpev_pkg::OFF_IRQST)
                   && wData[cmpev_pkg::IRQ_TRIP];

   // ---------------------------------------------------------------
   // Bus and register next state
   // ---------------------------------------------------------------
   always_comb
   begin
      next_awHeld = awHeld;
      next_wHeld  = wHeld;
      next_awAddr = awAddr;
      next_wData  = wData;
      next_wByte0 = wByte0;
      next_bValid = bValid;
      next_bResp  = bResp;
      next_rValid = rValid;
      next_rData  = rData;
      next_rResp  = rResp;
      next_ctrl   = ctrl;
      next_irqMsk = irqMsk;
      if (s_axi_awvalid && s_axi_awready)
      begin
         next_awHeld = 1'b1;
         next_awAddr = {s_axi_awaddr[7:2], 2'h0};
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
         next_wHeld  = 1'b1;
         next_wData  = s_axi_wdata;
         next_wByte0 = s_axi_wstrb[0];
      end
      if (doWrite)
      begin
         next_awHeld = 1'b0;
         next_wHeld  = 1'b0;
         next_bValid = 1'b1;
         next_bResp  = mapped(awAddr) ? cmpev_pkg::RESP_OKAY : cmpev_pkg::RESP_SLVERR;
         if (wByte0 && awAddr == cmpev_pkg::OFF_CTRL)
            next_ctrl = wData[cmpev_pkg::CTRL_W-1:0];
         if (wByte0 && awAddr == cmpev_pkg::OFF_IRQMSK)
            next_irqMsk = wData[cmpev_pkg::IRQ_W-1:0];
      end
      if (bValid && s_axi_bready)
         next_bValid = 1'b0;
      if (s_axi_arvalid && s_axi_arready)
      begin
         next_rValid = 1'b1;
         next_rResp  = mapped({s_axi_araddr[7:2], 2'h0}) ? cmpev_pkg::RESP_OKAY
                                                         : cmpev_pkg::RESP_SLVERR;
         unique case ({s_axi_araddr[7:2], 2'h0})
            cmpev_pkg::OFF_CTRL:   next_rData = {26'h0, ctrl};
            cmpev_pkg::OFF_STATUS: next_rData = {31'h0, result};
            cmpev_pkg::OFF_IRQST:  next_rData = {31'h0, irqSt};
            cmpev_pkg::OFF_IRQMSK: next_rData = {31'h0, irqMsk};
            default:               next_rData = 32'h0;
         endcase
      end
      else if (rValid && s_axi_rready)
         next_rValid = 1'b0;
   end

   // ---------------------------------------------------------------
   // Comparator state next values
   // ---------------------------------------------------------------
   always_comb
   begin
      next_cmpPrev = enable ? cmpSync : 1'b0;
      // Coming enable, so the result drops in the same cycle as the pins
      next_result  = next_ctrl[cmpev_pkg::CTRL_EN] ? cmpSync : 1'b0;
      next_irqSt   = irqSt;
      if (clrHit)
         next_irqSt[cmpev_pkg::IRQ_TRIP] = 1'b0;
      // Set wins over a clear in the same cycle, mask ignored
      if (trip)
         next_irqSt[cmpev_pkg::IRQ_TRIP] = 1'b1;
   end

   always_ff @(posedge clk_sys or negedge rstSync_b)
   begin
      if (!rstSync_b)
      begin
         awHeld  <= 1'b0;
         wHeld   <= 1'b0;
         awAddr  <= 8'h00;
         wData   <= 32'h0;
         wByte0  <= 1'b0;
         bValid  <= 1'b0;
         bResp   <= cmpev_pkg::RESP_OKAY;
         rValid  <= 1'b0;
         rData   <= 32'h0;
         rResp   <= cmpev_pkg::RESP_OKAY;
         ctrl    <= cmpev_pkg::CTRL_RST;
         irqMsk  <= cmpev_pkg::IRQ_RST;
         irqSt   <= cmpev_pkg::IRQ_RST;
         result  <= 1'b0;
         cmpPrev <= 1'b0;
      end
      else
      begin
         awHeld  <= next_awHeld;
         wHeld   <= next_wHeld;
         awAddr  <= next_awAddr;
         wData   <= next_wData;
         wByte0  <= next_wByte0;
         bValid  <= next_bValid;
         bResp   <= next_bResp;
         rValid  <= next_rValid;
         rData   <= next_rData;
         rResp   <= next_rResp;
         ctrl    <= next_ctrl;
         irqMsk  <= next_irqMsk;
         irqSt   <= next_irqSt;
         result  <= next_result;
         cmpPrev <= next_cmpPrev;
      end
   end

   // ---------------------------------------------------------------
   // Outputs
   // ---------------------------------------------------------------
   assign s_axi_awready = !awHeld && !bValid;
   assign s_axi_wready  = !wHeld && !bValid;
   assign s_axi_bvalid  = bValid;
   assign s_axi_bresp   = bResp;
   assign s_axi_arready = !rValid;
   assign s_axi_rvalid  = rValid;
   assign s_axi_rdata   = rData;
   assign s_axi_rresp   = rResp;

   assign anaCtrl.enable         = enable;
   assign anaCtrl.refSelInternal = ctrl[cmpev_pkg::CTRL_REFIN];
   assign anaCtrl.vrefOutEnable  = ctrl[cmpev_pkg::CTRL_VROUT];
   // Alarm level follows the result, inverted when polarity bit set
   assign alarmPin.out = result ^ ctrl[cmpev_pkg::CTRL_POL];
   assign alarmPin.oe  = enable && ctrl[cmpev_pkg::CTRL_OUTEN];
   assign pinsToGpio   = !enable;
   assign irq = |(irqSt & irqMsk) && ctrl[cmpev_pkg::CTRL_IRQEN];

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   a_trip_sets_flag: assert property (@(posedge clk_sys) disable iff (!rstSync_b)
      trip |=> irqSt[cmpev_pkg::IRQ_TRIP])
      else $error("Trip did not set flag");

   a_result_follows: assert property (@(posedge clk_sys) disable iff (!rstSync_b)
      enable && $past(enable) |-> result == $past(cmpSync))
      else $error("Result does not follow comparator");

   a_disabled_gpio: assert property (@(posedge clk_sys) disable iff (!rstSync_b)
      !enable |-> pinsToGpio && !alarmPin.oe && !result)
      else $error("Pins held while disabled");

   a_alarm_polarity: assert property (@(posedge clk_sys) disable iff (!rstSync_b)
      enable |-> alarmPin.out == ($past(cmpSync) != ctrl[cmpev_pkg::CTRL_POL]))
      else $error("Alarm polarity wrong");

   a_irq_flagmask: assert property (@(posedge clk_sys) disable iff (!rstSync_b)
      $rose(irq) |-> $past(trip) || $past(doWrite))
      else $error("Interrupt without cause");

   a_clear_flag: assert property (@(posedge clk_sys) disable iff (!rstSync_b)
      clrHit && !trip |=> !irqSt[cmpev_pkg::IRQ_TRIP])
      else $error("Flag clear failed");

   a_vref_route: assert property (@(posedge clk_sys) disable iff (!rstSync_b)
      $rose(ctrl[cmpev_pkg::CTRL_VROUT]) |-> anaCtrl.vrefOutEnable && $past(doWrite))
      else $error("Reference routing wrong");

   a_sync_delay: assert property (@(posedge clk_sys) disable iff (!rstSync_b)
      $rose(cmpSync) |-> $past(u_sync.stage[2]) && $past(u_sync.stage[1]))
      else $error("Synchronised edge before stages agreed");

   a_ref_select: assert property (@(posedge clk_sys) disable iff (!rstSync_b)
      anaCtrl.refSelInternal == ctrl[cmpev_pkg::CTRL_REFIN] ##1 $stable(anaCtrl.refSelInternal) || $past(doWrite))
      else $error("Reference select changed without write");

endmodule // cmpev_top

// >>> logic/cmpev_pkg.sv
// Package for the comparator event logic: register map, field layout, reset values.
// Assumes a 32-bit AXI4-Lite register bus and a 50 MHz system clock.
package cmpev_pkg;

   // ---------------------------------------------------------------
   // Register byte offsets
   // ---------------------------------------------------------------
   localparam logic [7:0] OFF_CTRL   = 8'h00;
   localparam logic [7:0] OFF_STATUS = 8'h04;
   localparam logic [7:0] OFF_IRQST  = 8'h08;
   localparam logic [7:0] OFF_IRQMSK = 8'h0C;

   // ---------------------------------------------------------------
   // Control register fields
   // ---------------------------------------------------------------
   localparam int CTRL_EN    = 0;
   localparam int CTRL_REFIN = 1;
   localparam int CTRL_POL   = 2;
   localparam int CTRL_OUTEN = 3;
   localparam int CTRL_IRQEN = 4;
   localparam int CTRL_VROUT = 5;
   localparam int CTRL_W     = 6;

   // ---------------------------------------------------------------
   // Status and interrupt fields
   // ---------------------------------------------------------------
   localparam int ST_RESULT  = 0;
   localparam int IRQ_TRIP   = 0;
   localparam int IRQ_W      = 1;

   // ---------------------------------------------------------------
   // Reset values and response codes
   // ---------------------------------------------------------------
   localparam logic [CTRL_W-1:0] CTRL_RST  = 6'h00;
   localparam logic [IRQ_W-1:0]  IRQ_RST   = 1'h0;
   localparam logic [1:0]        RESP_OKAY = 2'h0;
   localparam logic [1:0]        RESP_SLVERR = 2'h2;

   // Analog-facing control group
   typedef struct packed {
      logic enable;
      logic refSelInternal;
      logic vrefOutEnable;
   } cmpev_ana_t;

   // Alarm pin group
   typedef struct packed {
      logic out;
      logic oe;
   } cmpev_pin_t;

endpackage

// >>> logic/cmpev_sync.sv
// Three-stage synchroniser for the raw comparator output.
// Assumes the input is asynchronous to clk_sys.
`timescale 1ns/1ns
module cmpev_sync
(
   // Clock and reset
   input  wire logic clk_sys,
   input  wire logic rstSync_b,
   // Data
   input  wire logic din,
   output logic      dout
);

   logic [2:0] stage;
   logic [2:0] next_stage;
   logic       next_dout;

   always_comb
   begin
      next_stage = {stage[1:0], din};
      // Change counts once stages two and three agree
      next_dout  = (stage[1] == stage[2]) ? stage[2] : dout;
   end

   always_ff @(posedge clk_sys or negedge rstSync_b)
   begin
      if (!rstSync_b)
      begin
         stage <= 3'h0;
         dout  <= 1'b0;
      end
      else
      begin
         stage <= next_stage;
         dout  <= next_dout;
      end
   end

endmodule // cmpev_sync

// >>> testbench/cmpev_partner.sv
// Behavioural analog comparator and reference pin for the event logic.
// Assumes the bench sets the sensor and external reference levels in mV.
`timescale 1ns/1ns
module cmpev_partner
(
   // Controls from the event logic
   input  wire cmpev_pkg::cmpev_ana_t anaCtrl,
   // Analog scene
   input  wire logic [15:0]           sensorMv,
   input  wire logic [15:0]           extRefMv,
   // Comparator side
   output logic                       cmpRaw,
   output logic                       vrefPin
);
   logic [15:0] refMv;

   assign refMv   = anaCtrl.refSelInternal ? 16'h09C4 : extRefMv;
   // Output is a plain level, so glitches reach the synchroniser unfiltered
   assign cmpRaw  = anaCtrl.enable && (sensorMv > refMv);
   assign vrefPin = anaCtrl.vrefOutEnable;
endmodule // cmpev_partner

// >>> testbench/tb_top.sv
// Self-checking bench for the comparator event logic over AXI4-Lite.
// Assumes the behavioural comparator model stands at the analog side.
`timescale 1ns/1ns
module tb_top;
   typedef struct packed {
      logic [5:0]  ctrl;
      logic [15:0] lvl;
      logic [15:0] ext;
      logic        res;
   } cmpev_row_t;

   logic        clk_sys = 1'b0;
   logic        rst_b = 1'b1;
   logic        awV = 1'b0, wV = 1'b0, bRdy = 1'b0, arV = 1'b0, rRdy = 1'b0;
   logic        awR, wR, bV, arR, rV, cmpRaw, pinsToGpio, irq, vrefPin, tA, tD;
   logic [7:0]  awA = 8'h00, arA = 8'h00;
   logic [31:0] wD = 32'h0, rD, rdv;
   logic [3:0]  wS = 4'h0;
   logic [1:0]  bResp, rResp, resp;
   logic [15:0] sensorMv = 16'h0000, extRefMv = 16'h0000;
   cmpev_pkg::cmpev_ana_t anaCtrl;
   cmpev_pkg::cmpev_pin_t alarmPin;
   int          errors = 0;
   int          n_compared = 0;
   cmpev_row_t  rows [6] = '{'{6'h00, 16'h0BB8, 16'h0DAC, 1'b0}, '{6'h0B, 16'h0BB8, 16'h0DAC, 1'b1},
                             '{6'h0F, 16'h0BB8, 16'h0DAC, 1'b1}, '{6'h09, 16'h0BB8, 16'h0DAC, 1'b0},
                             '{6'h0D, 16'h0BB8, 16'h0DAC, 1'b0}, '{6'h23, 16'h07D0, 16'h0DAC, 1'b0}};

   always #10 clk_sys = ~clk_sys;

   cmpev_top cmpev_top_inst (.clk_sys(clk_sys), .rst_b(rst_b),
      .s_axi_awvalid(awV), .s_axi_awready(awR), .s_axi_awaddr(awA),
      .s_axi_wvalid(wV), .s_axi_wready(wR), .s_axi_wdata(wD), .s_axi_wstrb(wS),
      .s_axi_bvalid(bV), .s_axi_bready(bRdy), .s_axi_bresp(bResp),
      .s_axi_arvalid(arV), .s_axi_arready(arR), .s_axi_araddr(arA),
      .s_axi_rvalid(rV), .s_axi_rready(rRdy), .s_axi_rdata(rD), .s_axi_rresp(rResp),
      .cmpRaw(cmpRaw), .anaCtrl(anaCtrl), .alarmPin(alarmPin), .pinsToGpio(pinsToGpio), .irq(irq));

   cmpev_partner cmpev_partner_inst (.anaCtrl(anaCtrl), .sensorMv(sensorMv), .extRefMv(extRefMv),
      .cmpRaw(cmpRaw), .vrefPin(vrefPin));

   // ---------------------------------------------------------------
   // Reporting
   // ---------------------------------------------------------------
   task automatic final_report;
      $display("Compared %0d, mismatches %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   task automatic chkWord(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_compared++;
      if (got !== exp)
      begin
         errors++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask

   // Callers sample pins mid-cycle, away from the launching edge
   task automatic chkBit(input string what, input logic exp, input logic got);
      n_compared++;
      if (got !== exp)
      begin
         errors++;
         $display("Error %s expected %b seen %b", what, exp, got);
      end
   endtask

   // One bounded step to mid-cycle, where design outputs have settled
   task automatic waitStep(inout int n);
      @(negedge clk_sys);
      n++;
      if (n > 100)
      begin
         errors++;
         $display("Error bus wait expected answer seen none");
         final_report();
      end
   endtask

   // ---------------------------------------------------------------
   // AXI4-Lite master
   // ---------------------------------------------------------------
   task automatic axiWr(input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk_sys);
      awV  <= 1'b1;
      awA  <= a;
      wV   <= 1'b1;
      wD   <= d;
      wS   <= 4'hF;
      bRdy <= 1'b1;
      waitStep(n);
      // Address and data may be taken at different edges; response follows both
      while (bV !== 1'b1)
      begin
         tA = awV && awR;
         tD = wV && wR;
         @(posedge clk_sys);
         if (tA)
            awV <= 1'b0;
         if (tD)
            wV <= 1'b0;
         waitStep(n);
      end
      resp = bResp;
      @(posedge clk_sys);
      bRdy <= 1'b0;
      @(negedge clk_sys);
   endtask

   task automatic axiRd(input logic [7:0] a, output logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk_sys);
      arV  <= 1'b1;
      arA  <= a;
      rRdy <= 1'b1;
      waitStep(n);
      while (arR !== 1'b1)
         waitStep(n);
      @(posedge clk_sys);
      arV <= 1'b0;
      waitStep(n);
      while (rV !== 1'b1)
         waitStep(n);
      d = rD;
      resp = rResp;
      @(posedge clk_sys);
      rRdy <= 1'b0;
      @(negedge clk_sys);
   endtask

   // ---------------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------------
   initial
   begin
      rst_b <= 1'b0;
      repeat (4) @(posedge clk_sys);
      rst_b <= 1'b1;
      repeat (3) @(posedge clk_sys);
      @(negedge clk_sys);
      chkBit("irq", 1'b0, irq);
      chkBit("pinsToGpio", 1'b1, pinsToGpio);
      axiRd(cmpev_pkg::OFF_CTRL, rdv);
      chkWord("CTRL", 32'h0, rdv);
      $display("Test reset done");
      foreach (rows[i])
      begin
         sensorMv <= rows[i].lvl;
         extRefMv <= rows[i].ext;
         axiWr(cmpev_pkg::OFF_CTRL, {26'h0, rows[i].ctrl});
         repeat (8) @(posedge clk_sys);
         axiRd(cmpev_pkg::OFF_STATUS, rdv);
         chkWord("STATUS", {31'h0, rows[i].res}, rdv);
         chkBit("alarm out", rows[i].res ^ rows[i].ctrl[2], alarmPin.out);
         chkBit("alarm oe", rows[i].ctrl[0] & rows[i].ctrl[3], alarmPin.oe);
         chkBit("pinsToGpio", ~rows[i].ctrl[0], pinsToGpio);
         chkBit("ref select", rows[i].ctrl[1], anaCtrl.refSelInternal);
         chkBit("vref out", rows[i].ctrl[5], vrefPin);
      end
      $display("Test table done");
      sensorMv <= 16'h03E8;
      extRefMv <= 16'h07D0;
      axiWr(cmpev_pkg::OFF_IRQMSK, 32'h1);
      axiWr(cmpev_pkg::OFF_CTRL, 32'h11);
      repeat (8) @(posedge clk_sys);
      axiWr(cmpev_pkg::OFF_IRQST, 32'h1);
      chkBit("irq", 1'b0, irq);
      sensorMv <= 16'h0BB8;
      repeat (8) @(posedge clk_sys);
      @(negedge clk_sys);
      chkBit("irq", 1'b1, irq);
      axiWr(cmpev_pkg::OFF_IRQST, 32'h1);
      axiRd(cmpev_pkg::OFF_IRQST, rdv);
      chkWord("IRQST", 32'h0, rdv);
      chkBit("irq", 1'b0, irq);
      axiWr(cmpev_pkg::OFF_IRQMSK, 32'h0);
      sensorMv <= 16'h03E8;
      repeat (8) @(posedge clk_sys);
      sensorMv <= 16'h0BB8;
      repeat (8) @(posedge clk_sys);
      axiRd(cmpev_pkg::OFF_IRQST, rdv);
      chkWord("IRQST", 32'h1, rdv);
      chkBit("irq", 1'b0, irq);
      axiWr(cmpev_pkg::OFF_CTRL, 32'h01);
      axiWr(cmpev_pkg::OFF_IRQMSK, 32'h1);
      chkBit("irq", 1'b0, irq);
      axiWr(cmpev_pkg::OFF_CTRL, 32'h11);
      chkBit("irq", 1'b1, irq);
      $display("Test interrupt done");
      sensorMv <= 16'h03E8;
      repeat (8) @(posedge clk_sys);
      axiWr(cmpev_pkg::OFF_IRQST, 32'h1);
      // One-cycle glitch must not survive the synchroniser
      @(posedge clk_sys);
      sensorMv <= 16'h0BB8;
      @(posedge clk_sys);
      sensorMv <= 16'h03E8;
      repeat (8) @(posedge clk_sys);
      axiRd(cmpev_pkg::OFF_IRQST, rdv);
      chkWord("IRQST", 32'h0, rdv);
      axiWr(cmpev_pkg::OFF_STATUS, 32'h1);
      axiRd(cmpev_pkg::OFF_STATUS, rdv);
      chkWord("STATUS", 32'h0, rdv);
      axiRd(8'h10, rdv);
      chkWord("unmapped read", {30'h0, cmpev_pkg::RESP_SLVERR}, {rdv[29:0], resp});
      axiWr(8'h10, 32'h1);
      chkWord("unmapped write", {30'h0, cmpev_pkg::RESP_SLVERR}, {30'h0, resp});
      $display("Test edge cases done");
      axiWr(cmpev_pkg::OFF_CTRL, 32'h2B);
      @(posedge clk_sys);
      rst_b <= 1'b0;
      @(negedge clk_sys);
      chkBit("pinsToGpio", 1'b1, pinsToGpio);
      chkBit("alarm oe", 1'b0, alarmPin.oe);
      @(posedge clk_sys);
      rst_b <= 1'b1;
      repeat (3) @(posedge clk_sys);
      axiRd(cmpev_pkg::OFF_CTRL, rdv);
      chkWord("CTRL", 32'h0, rdv);
      $display("Test second reset done");
      final_report();
   end
endmodule // tb_top
